// *** src/ecr_defines.vh ***
// Register map, field positions, reset values and mode codes of the capture/compare channel.
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH
// ****************************************************************
// Register word addresses
// ****************************************************************
`define ECR_ADDR_W        3
`define ECR_OFF_VLOW      3'h0
`define ECR_OFF_VHIGH     3'h1
`define ECR_OFF_CTRL      3'h2
`define ECR_OFF_STATUS    3'h3
`define ECR_OFF_MASK      3'h4
`define ECR_OFF_TIMER     3'h5
// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define ECR_MODE_MSB      3
`define ECR_MODE_LSB      0
`define ECR_DUTY_MSB      5
`define ECR_DUTY_LSB      4
`define ECR_OCFG_MSB      7
`define ECR_OCFG_LSB      6
`define ECR_CTRL_RST      8'h00
`define ECR_BYTE_RST      8'h00
`define ECR_STAT_CAP      0
`define ECR_STAT_CMP      1
// ****************************************************************
// Mode select codes
// ****************************************************************
`define ECR_M_OFF         4'h0
`define ECR_M_CMP_TGL     4'h2
`define ECR_M_CAP_FALL    4'h4
`define ECR_M_CAP_RISE    4'h5
`define ECR_M_CAP_RISE4   4'h6
`define ECR_M_CAP_RISE16  4'h7
`define ECR_M_CMP_SET     4'h8
`define ECR_M_CMP_CLR     4'h9
`define ECR_M_PWM_LO      4'hC
`endif

// *** src/ecr_edge_sync.v ***
// Two-stage pin synchroniser with edge detection for the channel input.
`timescale 1ns/10ps
module ecr_edge_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire pin_i,
  output wire rise_o,
  output wire fall_o
);
  reg meta_r;
  reg sync_r;
  reg last_r;
  // Only sync_r and last_r feed the edge logic, never the first stage.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce_i) begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign rise_o = ce_i & sync_r & ~last_r;
  assign fall_o = ce_i & ~sync_r & last_r;
endmodule

// *** src/ecr_channel.v ***
// Capture, compare and PWM channel with its value and control registers.
// Operation
// - Capture stores the timer count into low byte and high byte.
// - Compare target is high byte over low byte.
// - In PWM the low byte holds the eight upper duty bits software writes.
// - In PWM the high byte buffers the duty used for the running period.
// - Mode zero switches the channel off and resets all its state except the interrupt mask.
// - Mode 0100 captures the timer on every falling pin edge.
// - Mode 1000 drives pin low, then high and flags on compare match.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/10ps
`include "ecr_defines.vh"
module ecr_channel (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [2:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire [15:0] timer_count_i,
  input  wire        period_end_i,
  input  wire        channel_pin_i,
  output reg         channel_pin_o,
  output reg         channel_pin_oe_o,
  output reg         output_a_o,
  output reg         irq_o
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [7:0] value_low_byte_r;
  reg  [7:0] value_high_byte_r;
  reg  [1:0] duty_buf_low_r;
  reg  [7:0] ctrl_r;
  reg  [1:0] status_r;
  reg  [1:0] mask_r;
  reg  [3:0] prescale_r;
  reg        done_r;
  wire       pin_rise;
  wire       pin_fall;
  wire [3:0] mode_select = ctrl_r[`ECR_MODE_MSB:`ECR_MODE_LSB];

  // Pin edges reach the capture logic two clock edges after they occur and are captured at the third.
  ecr_edge_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pin_i  (channel_pin_i),
    .rise_o (pin_rise),
    .fall_o (pin_fall)
  );

  function is_cap;
    input [3:0] m;
    begin
      is_cap = (m[3:2] == 2'b01);
    end
  endfunction

  function is_cmp;
    input [3:0] m;
    begin
      is_cmp = (m == `ECR_M_CMP_TGL) || (m[3:2] == 2'b10);
    end
  endfunction

  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = (m[3:2] == 2'b11);
    end
  endfunction

  // ****************************************************************
  // Capture event
  // ****************************************************************
  reg cap_evt;
  always @* begin
    cap_evt = 1'b0;
    case (mode_select)
      `ECR_M_CAP_FALL:   cap_evt = pin_fall;
      `ECR_M_CAP_RISE:   cap_evt = pin_rise;
      `ECR_M_CAP_RISE4:  cap_evt = pin_rise & (prescale_r[1:0] == 2'h3);
      `ECR_M_CAP_RISE16: cap_evt = pin_rise & (prescale_r == 4'hF);
      default:           cap_evt = 1'b0;
    endcase
  end

  wire cmp_match = is_cmp(mode_select) &&
                   (timer_count_i == {value_high_byte_r, value_low_byte_r});
  wire cmp_evt   = cmp_match & ~done_r;
  wire [9:0] duty_now = {value_high_byte_r, duty_buf_low_r};

  wire bus_req  = avs_read_i | avs_write_i;
  // Writes land at the edge where the master sees waitrequest low, never at the request edge.
  wire wr_go    = avs_write_i & ~avs_waitrequest_o & ce_i & avs_byteenable_i[0];
  wire mode_wr  = wr_go && (avs_address_i == `ECR_OFF_CTRL);
  wire st_wr    = wr_go && (avs_address_i == `ECR_OFF_STATUS);
  wire [1:0] clr_bits = st_wr ? avs_writedata_i[1:0] : 2'h0;
  wire [3:0] new_mode = avs_writedata_i[3:0];

  // ****************************************************************
  // Channel state
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      value_low_byte_r  <= `ECR_BYTE_RST;
      value_high_byte_r <= `ECR_BYTE_RST;
      duty_buf_low_r    <= 2'h0;
      ctrl_r            <= `ECR_CTRL_RST;
      status_r          <= 2'h0;
      mask_r            <= 2'h0;
      prescale_r        <= 4'h0;
      done_r            <= 1'b0;
      channel_pin_o     <= 1'b0;
      channel_pin_oe_o  <= 1'b0;
      output_a_o        <= 1'b0;
    end else if (ce_i) begin
      if (pin_rise && is_cap(mode_select)) begin
        prescale_r <= prescale_r + 4'h1;
      end
      if (cap_evt) begin
        value_low_byte_r  <= timer_count_i[7:0];
        value_high_byte_r <= timer_count_i[15:8];
      end
      if (cmp_evt) begin
        done_r <= 1'b1;
        case (mode_select)
          `ECR_M_CMP_SET: channel_pin_o <= 1'b1;
          `ECR_M_CMP_CLR: channel_pin_o <= 1'b0;
          `ECR_M_CMP_TGL: channel_pin_o <= ~channel_pin_o;
          default:        channel_pin_o <= channel_pin_o;
        endcase
      end
      // A match that persists raises one event; leaving the match rearms it.
      if (!cmp_match) begin
        done_r <= 1'b0;
      end
      // Reloading only at period end keeps a half-written duty from cutting a period short.
      // duty buffer reloads at period end.
      if (is_pwm(mode_select)) begin
        if (period_end_i) begin
          value_high_byte_r <= value_low_byte_r;
          duty_buf_low_r    <= ctrl_r[`ECR_DUTY_MSB:`ECR_DUTY_LSB];
        end
        output_a_o <= ({timer_count_i[7:0], 2'h0} < duty_now);
      end else begin
        output_a_o <= 1'b0;
      end
      // Event set beats a write-one clear in the same cycle.
      status_r <= (status_r & ~clr_bits) | {cmp_evt, cap_evt};
      if (wr_go) begin
        case (avs_address_i)
          `ECR_OFF_VLOW:  value_low_byte_r  <= avs_writedata_i[7:0];
          `ECR_OFF_VHIGH: value_high_byte_r <= avs_writedata_i[7:0];
          `ECR_OFF_CTRL:  ctrl_r            <= avs_writedata_i[7:0];
          `ECR_OFF_MASK:  mask_r            <= avs_writedata_i[1:0];
          default:        mask_r            <= mask_r;
        endcase
      end
      if (mode_wr) begin
        prescale_r <= 4'h0;
        done_r     <= 1'b0;
        channel_pin_oe_o <= (new_mode != `ECR_M_OFF) && !is_cap(new_mode);
        if (new_mode == `ECR_M_CMP_SET) begin
          channel_pin_o <= 1'b0;
        end
        if (new_mode == `ECR_M_CMP_CLR) begin
          channel_pin_o <= 1'b1;
        end
        // The mask stays, so software keeps its interrupt choice across mode zero.
        // mode zero resets the channel.
        if (new_mode == `ECR_M_OFF) begin
          value_low_byte_r  <= `ECR_BYTE_RST;
          value_high_byte_r <= `ECR_BYTE_RST;
          duty_buf_low_r    <= 2'h0;
          ctrl_r            <= `ECR_CTRL_RST;
          status_r          <= 2'h0;
          channel_pin_o     <= 1'b0;
          output_a_o        <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Avalon slave: one wait cycle, then the answer
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
      irq_o             <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status_r & mask_r);
      // Every request waits exactly one cycle, so reads and writes share one timing.
      if (bus_req && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        case (avs_address_i)
          `ECR_OFF_VLOW:   avs_readdata_o <= {24'h000000, value_low_byte_r};
          `ECR_OFF_VHIGH:  avs_readdata_o <= {24'h000000, value_high_byte_r};
          `ECR_OFF_CTRL:   avs_readdata_o <= {24'h000000, ctrl_r};
          `ECR_OFF_STATUS: avs_readdata_o <= {30'h0, status_r};
          `ECR_OFF_MASK:   avs_readdata_o <= {30'h0, mask_r};
          `ECR_OFF_TIMER:  avs_readdata_o <= {16'h0000, timer_count_i};
          default:         avs_readdata_o <= 32'h0000_0000;
        endcase
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/ecr_channel_asserts.sv ***
// Checker of bus timing, mode entry, compare, PWM and interrupt of the channel.
`timescale 1ns/10ps
module ecr_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire [2:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire [15:0] timer_count_i,
  input wire        period_end_i,
  input wire        channel_pin_i,
  input wire        channel_pin_o,
  input wire        channel_pin_oe_o,
  input wire        output_a_o,
  input wire        irq_o
);
  // ****
  // Shadow state
  // ****
  // Captures are not shadowed, so compare checks trust only values software wrote.
  reg  [7:0] lo_r, hi_r;
  reg  [3:0] md_r;
  reg  [1:0] dt_r, db_r, mk_r;
  reg        pv_r;
  wire       wr = ce_i && avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire [7:0] d = avs_writedata_i[7:0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      {lo_r, hi_r, md_r, dt_r, db_r, mk_r, pv_r} <= 27'h0;
    end else begin
      if (wr && avs_address_i == 3'h0) lo_r <= d;
      if (wr && avs_address_i == 3'h1) hi_r <= d;
      if (wr && avs_address_i == 3'h4) mk_r <= d[1:0];
      if (ce_i && period_end_i && md_r[3:2] == 2'h3) begin
        hi_r <= lo_r;
        db_r <= dt_r;
        pv_r <= 1'b1;
      end
      if (md_r[3:2] != 2'h3) pv_r <= 1'b0;
      if (wr && avs_address_i == 3'h2) begin
        md_r <= d[3:0];
        dt_r <= d[5:4];
        if (d[3:0] == 4'h0) {lo_r, hi_r, dt_r, db_r} <= 20'h0;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // Properties
  // ****
  property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer one cycle after request");
  property p_one; !avs_waitrequest_o && ce_i |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_off; wr && avs_address_i == 3'h2 && d[3:0] == 4'h0
    |-> ##[1:2] !channel_pin_oe_o && !output_a_o && !irq_o; endproperty
  a_off: assert property (p_off) else $error("channel still active after off");
  property p_cap; md_r == 4'h4 && mk_r[0] && $fell(channel_pin_i) |-> ##[2:6] irq_o; endproperty
  a_cap: assert property (p_cap) else $error("no capture event on falling edge");
  property p_cinit; wr && avs_address_i == 3'h2 && d[3:0] == 4'h8
    |-> ##[1:2] !channel_pin_o && channel_pin_oe_o; endproperty
  a_cinit: assert property (p_cinit) else $error("pin not driven low on entry");
  property p_cmp; md_r == 4'h8 && timer_count_i == {hi_r, lo_r} |-> ##[1:2] channel_pin_o;
  endproperty
  a_cmp: assert property (p_cmp) else $error("pin not set on match");
  property p_pwm; pv_r && $past(pv_r) && $past(ce_i) && md_r[3:2] == 2'h3
    |-> output_a_o == $past({timer_count_i[7:0], 2'h0} < {hi_r, db_r}); endproperty
  a_pwm: assert property (p_pwm) else $error("output not from buffered duty");
  property p_msk; mk_r == 2'h0 && $past(mk_r) == 2'h0 |-> !irq_o; endproperty
  a_msk: assert property (p_msk) else $error("interrupt while all masked");
endmodule
bind ecr_channel ecr_chk ecr_chk_inst (.clk_i, .rst_i, .ce_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .timer_count_i, .period_end_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_o,
  .output_a_o, .irq_o);

// *** testbench/tb_ecr_channel.sv ***
// Self-checking bench of the capture/compare channel.
`timescale 1ns/10ps
module tb_ecr_channel;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [2:0]  avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [15:0] timer_count_i = 0;
  logic        period_end_i = 0, channel_pin_i = 1, probe = 0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, channel_pin_o, channel_pin_oe_o, output_a_o, irq_o;
  logic [31:0] q[$];
  logic [31:0] e, g;
  logic [15:0] t;
  logic [7:0]  d;
  int          n_mismatch = 0, checked = 0;
  ecr_channel ecr_channel_inst (.clk_i, .rst_i, .ce_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .timer_count_i, .period_end_i, .channel_pin_i, .channel_pin_o, .channel_pin_oe_o,
    .output_a_o, .irq_o);
  initial forever #50 clk_i = ~clk_i;
  // ****
  // Bus tasks and monitor
  // ****
  task automatic rw(input bit w, input [2:0] a, input [31:0] v);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input [2:0] a, input [31:0] x);
    q.push_back(x);
    rw(0, a, 32'h0);
  endtask
  task automatic look(input [3:0] x);
    q.push_back({28'h0, x});
    @(posedge clk_i);
    probe <= 1'b1;
    @(posedge clk_i);
    probe <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if ((avs_read_i && avs_waitrequest_o === 1'b0) || probe) begin
      e = q.pop_front();
      g = probe ? {28'h0, irq_o, output_a_o, channel_pin_oe_o, channel_pin_o} : avs_readdata_o;
      checked++;
      if (g !== e) begin
        n_mismatch++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  end
  task summarize;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // The span is more than ten times the expected run, so slow answers are not cut short.
  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    summarize();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    void'($urandom(32'hD3B2540E));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    look(4'h0);
    t = 16'($urandom);
    rw(1, 3'h4, 32'h3);
    rw(1, 3'h2, 32'h4);
    timer_count_i <= t;
    channel_pin_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(3'h0, 32'(t[7:0]));
    rd(3'h1, 32'(t[15:8]));
    rd(3'h3, 32'h1);
    look(4'h8);
    rw(1, 3'h3, 32'h1);
    rd(3'h3, 32'h0);
    rw(1, 3'h2, 32'h5);
    t = 16'($urandom);
    timer_count_i <= t;
    channel_pin_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(3'h0, 32'(t[7:0]));
    rd(3'h3, 32'h1);
    rw(1, 3'h2, 32'h0);
    for (int a = 0; a < 4; a++) rd(a[2:0], 32'h0);
    rw(1, 3'h6, 32'hFF);
    rd(3'h6, 32'h0);
    timer_count_i <= 16'h1;
    t = 16'($urandom);
    t[1] = 1'b1;
    rw(1, 3'h2, 32'h8);
    rw(1, 3'h0, 32'(t[7:0]));
    rw(1, 3'h1, 32'(t[15:8]));
    rd(3'h3, 32'h0);
    look(4'h2);
    timer_count_i <= t;
    repeat (4) @(posedge clk_i);
    rd(3'h3, 32'h2);
    look(4'hB);
    rw(1, 3'h3, 32'h2);
    rd(3'h3, 32'h0);
    d = 8'($urandom);
    rw(1, 3'h0, 32'(d));
    rw(1, 3'h2, 32'h3C);
    rd(3'h0, 32'(d));
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      timer_count_i <= 16'($urandom);
      period_end_i <= (i % 16 == 7);
    end
    rd(3'h1, 32'(d));
    rw(1, 3'h0, {24'h0, ~d});
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    period_end_i <= 1'b1;
    @(posedge clk_i);
    period_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(3'h1, 32'(d));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    look(4'h0);
    avs_byteenable_i <= 4'hE;
    rw(1, 3'h0, 32'h5A);
    avs_byteenable_i <= 4'hF;
    rd(3'h0, 32'h0);
    rd(3'h4, 32'h0);
    rw(1, 3'h4, 32'h0);
    summarize();
  end
endmodule
